//--- core/hpc_pkg.sv
// constants of the host port control register block
// assumes one 50 MHz clock and a synchronous active-high reset

package hpc_pkg;

	localparam logic [15:0] CTRL_CPU_ADDR = 16'h002c;

	localparam int LOW_W  = 16;
	localparam int EXT_W  = 7;
	localparam int ADDR_W = LOW_W + EXT_W;

	// host byte positions, mirrored in both bytes
	localparam int H_XSEL = 4;
	localparam int H_P2H  = 3;
	localparam int H_H2P  = 2;
	localparam int H_BOB  = 0;

	// processor word positions
	localparam int C_ENA   = 7;
	localparam int C_P2H   = 3;
	localparam int C_H2P   = 2;
	localparam int C_MUST1 = 1;

	// register select codes {hi, lo}
	localparam logic [1:0] SEL_CONTROL  = 2'h0;
	localparam logic [1:0] SEL_DATA_INC = 2'h1;
	localparam logic [1:0] SEL_ADDRESS  = 2'h2;

	localparam logic            BOB_RST  = 1'h0;
	localparam logic            P2H_RST  = 1'h0;
	localparam logic [LOW_W-1:0] LOW_RST = 16'h0000;
	localparam logic [7:0]      BYTE_ZERO = 8'h00;

endpackage

//--- core/hpc_byte_pair.sv
// pairs two host bytes into a word and splits a word into host bytes
// assumes byte identify low on the first byte and high on the second
`timescale 1ns/100ps

module hpc_byte_pair (
	input  wire logic        core_clk,
	input  wire logic        srst,
	input  wire logic        firstWrite,
	input  wire logic [7:0]  byteIn,
	input  wire logic        byteOrderSel,
	input  wire logic        byteIdentify,
	input  wire logic [15:0] wordOut,
	output logic      [15:0] wordIn,
	output logic      [7:0]  byteOut
);

	logic [7:0] firstByte_r;
	logic [7:0] firstByte_nxt;

	always_comb begin
		firstByte_nxt = firstByte_r;
		if (firstWrite)
			firstByte_nxt = byteIn;
	end

	always_ff @(posedge core_clk) begin
		if (srst)
			firstByte_r <= hpc_pkg::BYTE_ZERO;
		else
			firstByte_r <= firstByte_nxt;
	end

	// first byte low when order bit set, high otherwise
	always_comb begin
		if (byteOrderSel)
			wordIn = {byteIn, firstByte_r};
		else
			wordIn = {firstByte_r, byteIn};
		if (byteIdentify ^ byteOrderSel)
			byteOut = wordOut[7:0];
		else
			byteOut = wordOut[15:8];
	end

	AST_ORDER_PAIR: assert property (
		@(posedge core_clk) disable iff (srst)
		firstWrite |=> (byteOrderSel ? wordIn[7:0] : wordIn[15:8])
			== $past(byteIn))
		else $error("first byte not placed by byte order");

endmodule

//--- core/hpc_address_pointer.sv
// lower and extended host address bits with load and autoincrement
// assumes load and increment never come in the same cycle
`timescale 1ns/100ps

module hpc_address_pointer (
	input  wire logic                        core_clk,
	input  wire logic                        srst,
	input  wire logic                        load,
	input  wire logic                        extSel,
	input  wire logic [hpc_pkg::LOW_W-1:0]   loadWord,
	input  wire logic                        increment,
	output logic      [hpc_pkg::ADDR_W-1:0]  pointer
);

	logic [hpc_pkg::LOW_W-1:0] low_r;
	logic [hpc_pkg::LOW_W-1:0] low_nxt;
	logic [hpc_pkg::EXT_W-1:0] ext_r;
	logic [hpc_pkg::EXT_W-1:0] ext_nxt;

	always_comb begin
		{ext_nxt, low_nxt} = {ext_r, low_r};
		if (load && extSel)
			ext_nxt = loadWord[hpc_pkg::EXT_W-1:0];
		else if (load)
			low_nxt = loadWord;
		else if (increment)
			{ext_nxt, low_nxt} = {ext_r, low_r} + 1'b1;
	end

	// extended bits carry no reset value
	always_ff @(posedge core_clk) begin
		ext_r <= ext_nxt;
	end

	always_ff @(posedge core_clk) begin
		if (srst)
			low_r <= hpc_pkg::LOW_RST;
		else
			low_r <= low_nxt;
	end

	assign pointer = {ext_r, low_r};

	AST_INC_CARRY: assert property (
		@(posedge core_clk) disable iff (srst)
		(increment && !load) |=> pointer == $past(pointer) + 1'b1)
		else $error("pointer did not count as one word");

	AST_EXT_LOAD: assert property (
		@(posedge core_clk) disable iff (srst)
		(load && extSel) |=> low_r == $past(low_r))
		else $error("extended load disturbed lower bits");

endmodule

//--- core/hpc_control_register.sv
// host port control register: host byte side and processor word side
// assumes host and processor inputs synchronous to core_clk, one strobe
// per host byte, one cycle per processor access
`timescale 1ns/100ps

module hpc_control_register (
	input  wire logic                       core_clk,
	input  wire logic                       srst,
	input  wire logic                       portEnablePin,
	input  wire logic                       hostStrobe,
	input  wire logic                       hostWrite,
	input  wire logic                       registerSelectLo,
	input  wire logic                       registerSelectHi,
	input  wire logic                       byteIdentify,
	input  wire logic [7:0]                 hostWdata,
	output logic      [7:0]                 hostRdata,
	input  wire logic [15:0]                cpuAddr,
	input  wire logic                       cpuWrite,
	input  wire logic                       cpuRead,
	input  wire logic [15:0]                cpuWdata,
	output logic      [15:0]                cpuRdata,
	output logic                            cpuIrq,
	output logic                            hostIrqN,
	output logic      [hpc_pkg::ADDR_W-1:0] memAddress
);

	////////////////////////////////////////////////////////////////////////
	// decode

	logic [1:0] regSel;
	logic       ctrlSel;
	logic       addrSel;
	logic       incSel;
	logic       hostSecond;
	logic       hostCtrlWr;
	logic       hostCtrlRd;
	logic       hostAddrWr;
	logic       hostAddrRd;
	logic       cpuHit;
	logic       cpuCtrlWr;
	logic       cpuCtrlRd;

	assign regSel     = {registerSelectHi, registerSelectLo};
	assign ctrlSel    = regSel == hpc_pkg::SEL_CONTROL;
	assign addrSel    = regSel == hpc_pkg::SEL_ADDRESS;
	assign incSel     = regSel == hpc_pkg::SEL_DATA_INC;
	assign hostSecond = hostStrobe && byteIdentify;
	// only the second byte of a control write takes effect
	assign hostCtrlWr = hostSecond && hostWrite && ctrlSel;
	assign hostCtrlRd = hostStrobe && !hostWrite && ctrlSel;
	assign hostAddrWr = hostSecond && hostWrite && addrSel;
	assign hostAddrRd = hostStrobe && !hostWrite && addrSel;
	assign cpuHit     = cpuAddr == hpc_pkg::CTRL_CPU_ADDR;
	assign cpuCtrlWr  = cpuWrite && cpuHit;
	assign cpuCtrlRd  = cpuRead && cpuHit;

	////////////////////////////////////////////////////////////////////////
	// control bits

	logic byteOrderSel_r;
	logic byteOrderSel_nxt;
	logic p2hIrq_r;
	logic p2hIrq_nxt;
	logic cpuIrq_r;
	logic cpuIrq_nxt;
	logic extSelect_r;
	logic extSelect_nxt;
	logic portEnable_r;
	logic portEnable_nxt;

	always_comb begin
		byteOrderSel_nxt = byteOrderSel_r;
		p2hIrq_nxt       = p2hIrq_r;
		cpuIrq_nxt       = 1'b0;
		extSelect_nxt    = extSelect_r;
		portEnable_nxt   = portEnable_r;
		if (hostCtrlWr) begin
			byteOrderSel_nxt = hostWdata[hpc_pkg::H_BOB];
			extSelect_nxt    = hostWdata[hpc_pkg::H_XSEL];
			cpuIrq_nxt       = hostWdata[hpc_pkg::H_H2P];
			if (hostWdata[hpc_pkg::H_P2H])
				p2hIrq_nxt = 1'b0;
		end
		// processor set wins over a host clear in the same cycle
		if (cpuCtrlWr && cpuWdata[hpc_pkg::C_P2H])
			p2hIrq_nxt = 1'b1;
	end

	always_ff @(posedge core_clk) begin
		if (srst) begin
			byteOrderSel_r <= hpc_pkg::BOB_RST;
			p2hIrq_r       <= hpc_pkg::P2H_RST;
			cpuIrq_r       <= 1'b0;
		end else begin
			byteOrderSel_r <= byteOrderSel_nxt;
			p2hIrq_r       <= p2hIrq_nxt;
			cpuIrq_r       <= cpuIrq_nxt;
		end
	end

	// no reset value for the extended select
	always_ff @(posedge core_clk) begin
		extSelect_r <= extSelect_nxt;
	end

	// enable pin level followed while reset is asserted, held after release
	always_ff @(posedge core_clk) begin
		if (srst)
			portEnable_r <= portEnablePin;
		else
			portEnable_r <= portEnable_nxt;
	end

	assign cpuIrq   = cpuIrq_r;
	assign hostIrqN = !p2hIrq_r;

	////////////////////////////////////////////////////////////////////////
	// address pointer and byte pairing

	logic [15:0]                lowWord;
	logic [15:0]                pairWord;
	logic [7:0]                 pairByte;
	logic [15:0]                loadWord;
	logic [hpc_pkg::ADDR_W-1:0] pointer;

	assign lowWord = pointer[hpc_pkg::LOW_W-1:0];
	// extended loads take the second byte only
	assign loadWord = extSelect_r ? {hpc_pkg::BYTE_ZERO, hostWdata}
		: pairWord;

	hpc_byte_pair u_pair (
		.core_clk     (core_clk),
		.srst         (srst),
		.firstWrite   (hostStrobe && hostWrite && !byteIdentify),
		.byteIn       (hostWdata),
		.byteOrderSel (byteOrderSel_r),
		.byteIdentify (byteIdentify),
		.wordOut      (lowWord),
		.wordIn       (pairWord),
		.byteOut      (pairByte)
	);

	hpc_address_pointer u_ptr (
		.core_clk  (core_clk),
		.srst      (srst),
		.load      (hostAddrWr),
		.extSel    (extSelect_r),
		.loadWord  (loadWord),
		.increment (hostSecond && incSel),
		.pointer   (pointer)
	);

	assign memAddress = pointer;

	////////////////////////////////////////////////////////////////////////
	// read paths

	logic [7:0]  ctrlHostByte;
	logic [15:0] ctrlCpuWord;
	logic [7:0]  extByte;
	logic [7:0]  hostRdata_r;
	logic [7:0]  hostRdata_nxt;
	logic [15:0] cpuRdata_r;
	logic [15:0] cpuRdata_nxt;

	// same byte served for first and second host read
	always_comb begin
		ctrlHostByte                 = hpc_pkg::BYTE_ZERO;
		ctrlHostByte[hpc_pkg::H_XSEL] = extSelect_r;
		ctrlHostByte[hpc_pkg::H_P2H]  = p2hIrq_r;
		ctrlHostByte[hpc_pkg::H_BOB]  = byteOrderSel_r;
	end

	// upper byte and other bits read zero
	always_comb begin
		ctrlCpuWord                  = {2{hpc_pkg::BYTE_ZERO}};
		ctrlCpuWord[hpc_pkg::C_ENA]  = portEnable_r;
		ctrlCpuWord[hpc_pkg::C_P2H]  = p2hIrq_r;
	end

	assign extByte = {1'b0, pointer[hpc_pkg::ADDR_W-1:hpc_pkg::LOW_W]};

	always_comb begin
		hostRdata_nxt = hostRdata_r;
		if (hostCtrlRd)
			hostRdata_nxt = ctrlHostByte;
		else if (hostAddrRd)
			hostRdata_nxt = extSelect_r ? extByte : pairByte;
		else if (hostStrobe && !hostWrite)
			hostRdata_nxt = hpc_pkg::BYTE_ZERO;
	end

	always_comb begin
		cpuRdata_nxt = cpuRdata_r;
		if (cpuRead)
			cpuRdata_nxt = cpuHit ? ctrlCpuWord : {2{hpc_pkg::BYTE_ZERO}};
	end

	always_ff @(posedge core_clk) begin
		if (srst) begin
			hostRdata_r <= hpc_pkg::BYTE_ZERO;
			cpuRdata_r  <= {2{hpc_pkg::BYTE_ZERO}};
		end else begin
			hostRdata_r <= hostRdata_nxt;
			cpuRdata_r  <= cpuRdata_nxt;
		end
	end

	assign hostRdata = hostRdata_r;
	assign cpuRdata  = cpuRdata_r;

	////////////////////////////////////////////////////////////////////////
	// checks

	AST_BOB_RESET: assert property (
		@(posedge core_clk) disable iff (srst)
		$fell(srst) |-> byteOrderSel_r == hpc_pkg::BOB_RST)
		else $error("byte order not cleared by reset");

	AST_H2P_RAISE: assert property (
		@(posedge core_clk) disable iff (srst)
		(hostCtrlWr && hostWdata[hpc_pkg::H_H2P]) |=> cpuIrq ##1 !cpuIrq)
		else $error("host interrupt write gave no single pulse");

	AST_H2P_QUIET: assert property (
		@(posedge core_clk) disable iff (srst)
		!(hostCtrlWr && hostWdata[hpc_pkg::H_H2P]) |=> !cpuIrq)
		else $error("processor interrupt without host write");

	AST_H2P_READS_ZERO: assert property (
		@(posedge core_clk) disable iff (srst)
		hostCtrlRd |=> !hostRdata[hpc_pkg::H_H2P])
		else $error("host-to-processor bit read nonzero by host");

	AST_H2P_CPU_ZERO: assert property (
		@(posedge core_clk) disable iff (srst)
		cpuCtrlRd |=> !cpuRdata[hpc_pkg::C_H2P])
		else $error("host-to-processor bit read nonzero by processor");

	AST_P2H_SET: assert property (
		@(posedge core_clk) disable iff (srst)
		(cpuCtrlWr && cpuWdata[hpc_pkg::C_P2H]) |=> !hostIrqN)
		else $error("host interrupt pin not driven low after set");

	AST_P2H_CLEAR: assert property (
		@(posedge core_clk) disable iff (srst)
		(hostCtrlWr && hostWdata[hpc_pkg::H_P2H]
			&& !(cpuCtrlWr && cpuWdata[hpc_pkg::C_P2H])) |=> hostIrqN)
		else $error("host write of one did not clear interrupt");

	AST_P2H_HOLD: assert property (
		@(posedge core_clk) disable iff (srst)
		!(hostCtrlWr && hostWdata[hpc_pkg::H_P2H]) && !cpuCtrlWr
			|=> $stable(hostIrqN))
		else $error("host interrupt changed without a cause");

	AST_EXT_READ: assert property (
		@(posedge core_clk) disable iff (srst)
		(hostAddrRd && extSelect_r) |=>
			hostRdata[6:0] == $past(pointer[hpc_pkg::ADDR_W-1:hpc_pkg::LOW_W]))
		else $error("extended address read returned wrong bits");

	AST_ENA_FROZEN: assert property (
		@(posedge core_clk) disable iff (srst)
		!$fell(srst) |-> $stable(portEnable_r))
		else $error("enable status changed outside reset");

	AST_CTRL_MIRROR: assert property (
		@(posedge core_clk) disable iff (srst)
		hostCtrlRd |=> hostRdata[hpc_pkg::H_XSEL] == $past(extSelect_r)
			&& hostRdata[hpc_pkg::H_BOB] == $past(byteOrderSel_r)
			&& hostRdata[hpc_pkg::H_P2H] == $past(p2hIrq_r))
		else $error("control byte does not show control bits");

	AST_CPU_UPPER_ZERO: assert property (
		@(posedge core_clk) disable iff (srst)
		cpuRead |=> cpuRdata[15:8] == hpc_pkg::BYTE_ZERO
			&& cpuRdata[hpc_pkg::C_ENA] == ($past(cpuHit) && portEnable_r))
		else $error("processor read upper byte or enable wrong");

	AST_FIRST_DISCARD: assert property (
		@(posedge core_clk) disable iff (srst)
		(hostStrobe && hostWrite && !byteIdentify && ctrlSel
			&& !cpuCtrlWr) |=> $stable(p2hIrq_r) && !cpuIrq)
		else $error("first control byte took effect");

	AST_BOB_WRITE: assert property (
		@(posedge core_clk) disable iff (srst)
		hostCtrlWr |=>
			byteOrderSel_r == $past(hostWdata[hpc_pkg::H_BOB]))
		else $error("byte order not taken from control write");

	AST_XSEL_WRITE: assert property (
		@(posedge core_clk) disable iff (srst)
		hostCtrlWr |=>
			extSelect_r == $past(hostWdata[hpc_pkg::H_XSEL]))
		else $error("extended select not taken from control write");

	AST_CPU_NO_ORDER: assert property (
		@(posedge core_clk) disable iff (srst)
		(cpuCtrlWr && !hostCtrlWr) |=> $stable(byteOrderSel_r))
		else $error("processor write reached the byte order bit");

	AST_UNMAPPED_ZERO: assert property (
		@(posedge core_clk) disable iff (srst)
		(cpuRead && !cpuHit) |=>
			cpuRdata == {2{hpc_pkg::BYTE_ZERO}})
		else $error("unmapped processor read returned nonzero");

endmodule

//--- tb/hpc_host_model.sv
// host side byte bus model for the control register block
// assumes calls from the bench; drives just after rising core_clk edges
`timescale 1ns/100ps

module hpc_host_model (
	input  wire logic       core_clk,
	input  wire logic [7:0] hostRdata,
	output logic            hostStrobe,
	output logic            hostWrite,
	output logic            registerSelectLo,
	output logic            registerSelectHi,
	output logic            byteIdentify,
	output logic      [7:0] hostWdata
);
	initial begin
		hostStrobe = 1'h0;
		hostWrite = 1'h0;
		{registerSelectHi, registerSelectLo} = 2'h3;
		byteIdentify = 1'h1;
		hostWdata = 8'h00;
	end

	////////////////////////////////////////////////////////////
	// one two-byte transfer, read bytes returned in r0 and r1
	task automatic xfer(input logic wr, input logic [1:0] sel,
		input logic [7:0] b0, input logic [7:0] b1,
		output logic [7:0] r0, output logic [7:0] r1);
		logic [7:0] dat [2];
		dat[0] = b0;
		dat[1] = b1;
		@(posedge core_clk);
		#1;
		for (int i = 0; i < 2; i++) begin
			hostStrobe = 1'h1;
			hostWrite = wr;
			{registerSelectHi, registerSelectLo} = sel;
			byteIdentify = i[0];
			hostWdata = dat[i];
			@(posedge core_clk);
			#1;
			if (i == 0) r0 = hostRdata;
			else r1 = hostRdata;
		end
		hostStrobe = 1'h0;
		// released bus shows no stale byte
		hostWdata = ~hostWdata;
	endtask
endmodule

//--- tb/hpc_control_register_tb.sv
// self-checking bench for the host port control register
// assumes hpc_host_model as the host and a 50 MHz core_clk
`timescale 1ns/100ps

module hpc_control_register_tb;
	logic                       core_clk, srst, portEnablePin;
	logic                       hostStrobe, hostWrite, byteIdentify;
	logic                       registerSelectLo, registerSelectHi;
	logic                       cpuWrite, cpuRead, cpuIrq, hostIrqN, q;
	logic [7:0]                 hostWdata, hostRdata, r, r1, w, e8;
	logic [15:0]                cpuAddr, cpuWdata, cpuRdata, d;
	logic [hpc_pkg::ADDR_W-1:0] memAddress;
	int                         n_mismatch, num_checks;

	// control byte written, byte read back, processor irq pulse
	localparam logic [16:0] ROWS [5] = '{
		{8'h01, 8'h01, 1'h0}, {8'h05, 8'h01, 1'h1}, {8'h10, 8'h10, 1'h0},
		{8'h14, 8'h10, 1'h1}, {8'h00, 8'h00, 1'h0}};

	hpc_control_register DUT (
		.core_clk         (core_clk),
		.srst             (srst),
		.portEnablePin    (portEnablePin),
		.hostStrobe       (hostStrobe),
		.hostWrite        (hostWrite),
		.registerSelectLo (registerSelectLo),
		.registerSelectHi (registerSelectHi),
		.byteIdentify     (byteIdentify),
		.hostWdata        (hostWdata),
		.hostRdata        (hostRdata),
		.cpuAddr          (cpuAddr),
		.cpuWrite         (cpuWrite),
		.cpuRead          (cpuRead),
		.cpuWdata         (cpuWdata),
		.cpuRdata         (cpuRdata),
		.cpuIrq           (cpuIrq),
		.hostIrqN         (hostIrqN),
		.memAddress       (memAddress)
	);

	hpc_host_model host (
		.core_clk         (core_clk),
		.hostRdata        (hostRdata),
		.hostStrobe       (hostStrobe),
		.hostWrite        (hostWrite),
		.registerSelectLo (registerSelectLo),
		.registerSelectHi (registerSelectHi),
		.byteIdentify     (byteIdentify),
		.hostWdata        (hostWdata)
	);

	initial begin
		core_clk = 1'h0;
		forever #10 core_clk = ~core_clk;
	end

	////////////////////////////////////////////////////////////
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		num_checks++;
		if (s !== e) begin
			n_mismatch++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask

	task automatic end_sim();
		$display("checks %0d mismatches %0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	// pin flips after release to show it is latched
	task automatic doReset(input logic p);
		@(posedge core_clk);
		#1;
		srst = 1'h1;
		portEnablePin = p;
		repeat (3) @(posedge core_clk);
		#1;
		srst = 1'h0;
		portEnablePin = ~p;
	endtask

	task automatic cpuAcc(input logic wr, input logic [15:0] a,
		input logic [15:0] wd);
		@(posedge core_clk);
		#1;
		cpuAddr = a;
		cpuWdata = wd;
		cpuWrite = wr;
		cpuRead = ~wr;
		@(posedge core_clk);
		#1;
		cpuWrite = 1'h0;
		cpuRead = 1'h0;
		cpuWdata = ~wd;
		d = cpuRdata;
	endtask

	task automatic ctrlWr(input logic [7:0] b0, input logic [7:0] b1);
		host.xfer(1'h1, hpc_pkg::SEL_CONTROL, b0, b1, r, r1);
	endtask

	task automatic ctrlRd();
		host.xfer(1'h0, hpc_pkg::SEL_CONTROL, 8'h00, 8'h00, r, r1);
		chk(r1, r);
	endtask

	task automatic adr(input logic wr, input logic [1:0] sel,
		input logic [7:0] b0, input logic [7:0] b1);
		host.xfer(wr, sel, b0, b1, r, r1);
	endtask

	////////////////////////////////////////////////////////////
	initial begin
		srst = 1'h1;
		portEnablePin = 1'h1;
		cpuAddr = 16'h0000;
		cpuWdata = 16'h0000;
		cpuWrite = 1'h0;
		cpuRead = 1'h0;
		n_mismatch = 0;
		num_checks = 0;
		doReset(1'h1);
		chk(hostIrqN, 1'h1);
		chk(cpuIrq, 1'h0);
		for (int i = 0; i < 5; i++) begin
			{w, e8, q} = ROWS[i];
			ctrlWr(w, w);
			chk(cpuIrq, q);
			@(posedge core_clk);
			#1;
			chk(cpuIrq, 1'h0);
			ctrlRd();
			chk(r, e8);
		end
		cpuAcc(1'h1, hpc_pkg::CTRL_CPU_ADDR, 16'h000a);
		chk(hostIrqN, 1'h0);
		ctrlRd();
		chk(r, 8'h08);
		ctrlWr(8'h00, 8'h00);
		chk(hostIrqN, 1'h0);
		cpuAcc(1'h1, hpc_pkg::CTRL_CPU_ADDR, 16'h0002);
		chk(hostIrqN, 1'h0);
		cpuAcc(1'h0, hpc_pkg::CTRL_CPU_ADDR, 16'h0000);
		chk(d, 16'h0088);
		ctrlWr(8'h08, 8'h08);
		chk(hostIrqN, 1'h1);
		cpuAcc(1'h1, hpc_pkg::CTRL_CPU_ADDR, 16'hff73);
		cpuAcc(1'h0, hpc_pkg::CTRL_CPU_ADDR, 16'h0000);
		chk(d, 16'h0080);
		ctrlRd();
		chk(r, 8'h00);
		cpuAcc(1'h1, 16'h002d, 16'h000a);
		chk(hostIrqN, 1'h1);
		cpuAcc(1'h0, 16'h002d, 16'h0000);
		chk(d, 16'h0000);
		ctrlWr(8'h00, 8'h01);
		ctrlRd();
		chk(r, 8'h01);
		ctrlWr(8'h01, 8'h00);
		ctrlRd();
		chk(r, 8'h00);
		adr(1'h1, hpc_pkg::SEL_ADDRESS, 8'h12, 8'h34);
		chk(memAddress[15:0], 16'h1234);
		adr(1'h0, hpc_pkg::SEL_ADDRESS, 8'h00, 8'h00);
		chk({r, r1}, 16'h1234);
		ctrlWr(8'h01, 8'h01);
		adr(1'h1, hpc_pkg::SEL_ADDRESS, 8'h12, 8'h34);
		chk(memAddress[15:0], 16'h3412);
		ctrlWr(8'h10, 8'h10);
		adr(1'h1, hpc_pkg::SEL_ADDRESS, 8'h05, 8'h05);
		adr(1'h0, hpc_pkg::SEL_ADDRESS, 8'h00, 8'h00);
		chk({r, r1}, 16'h0505);
		ctrlWr(8'h00, 8'h00);
		adr(1'h1, hpc_pkg::SEL_ADDRESS, 8'hff, 8'hff);
		chk(memAddress, 23'h05ffff);
		adr(1'h0, 2'h3, 8'h00, 8'h00);
		chk(memAddress, 23'h05ffff);
		adr(1'h0, hpc_pkg::SEL_DATA_INC, 8'h00, 8'h00);
		chk(memAddress, 23'h060000);
		// processor sets the host interrupt between the two read bytes
		fork
			host.xfer(1'h0, hpc_pkg::SEL_CONTROL, 8'h00, 8'h00, r, r1);
			cpuAcc(1'h1, hpc_pkg::CTRL_CPU_ADDR, 16'h000a);
		join
		chk(r, 8'h00);
		chk(r1, 8'h08);
		ctrlWr(8'h01, 8'h01);
		doReset(1'h0);
		chk(hostIrqN, 1'h1);
		cpuAcc(1'h0, hpc_pkg::CTRL_CPU_ADDR, 16'h0000);
		chk(d, 16'h0000);
		ctrlRd();
		chk({r[3], r[0]}, 2'h0);
		end_sim();
	end

	// hang guard
	initial begin
		repeat (5000) @(posedge core_clk);
		n_mismatch++;
		end_sim();
	end
endmodule
